// ---- src/bstp_consts.svh ----
// Purpose: shared constants of the boundary-scan test port
// Assumes: included by its bare name from every design file but bstp_pkg
// Notes:   opcodes, pin slots and reset values live here, types in bstp_pkg
`ifndef BSTP_CONSTS_SVH
`define BSTP_CONSTS_SVH

// instruction register width and opcodes
`define BSTP_IR_W         4
`define BSTP_OP_EXTEST    4'h0
`define BSTP_OP_SAMPLE    4'h1
`define BSTP_OP_IDCODE    4'h2
`define BSTP_OP_HIGHZ     4'h3
`define BSTP_OP_BYPASS    4'hf
// value loaded into the instruction shifter on capture (low bits 01)
`define BSTP_IR_CAPTURE   4'h1
// instruction after a test port reset
`define BSTP_IR_RESET     4'h2
`define BSTP_ID_W         32

// slots of the four test port pins in the tap pin vectors
`define BSTP_PIN_TDI      0
`define BSTP_PIN_TMS      1
`define BSTP_PIN_TCK      2
`define BSTP_PIN_TDO      3
`define BSTP_TAP_PINS     4

// stages of one boundary cell
`define BSTP_CELL_STAGES  3
`define BSTP_STG_PIN      0
`define BSTP_STG_OUT      1
`define BSTP_STG_OE       2

`endif

// ---- src/bstp_pkg.sv ----
// Purpose: types of the boundary-scan test port
// Assumes: nothing beyond the language
// Notes:   state encoding left to the tools
`default_nettype none

package bstp_pkg;

    // the sixteen states of the test port controller
    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE,
        TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
        TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR,
        TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR,
        TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
    } bstp_tap_state_type;

endpackage

`default_nettype wire

// ---- src/bstp_cell.sv ----
// Purpose: one boundary cell with three shift stages and two update stages
// Assumes: controls come from the test port controller on the test clock
// Notes:   input cells keep no update stages
`include "bstp_consts.svh"
`default_nettype none

module bstp_cell
    import bstp_pkg::*;
#(
    parameter bit IS_MACRO = 1'b1
) (
    input  wire logic                          i_tck,
    input  wire logic                          i_rst,
    input  wire logic                          i_capture,
    input  wire logic                          i_shift,
    input  wire logic                          i_update,
    input  wire logic                          i_scan_in,
    input  wire logic [`BSTP_CELL_STAGES-1:0]  i_cap,
    output logic                               o_scan_out,
    output logic                               o_upd_out,
    output logic                               o_upd_oe
);

    typedef struct packed {
        logic [`BSTP_CELL_STAGES-1:0] stg;
        logic                         upd_out;
        logic                         upd_oe;
    } bstp_cell_st_type;

    bstp_cell_st_type q, d;

    // capture takes live values, shift moves data toward the chain output
    always_comb begin
        d = q;
        if (i_capture) begin
            d.stg = i_cap;
        end else if (i_shift) begin
            d.stg = {i_scan_in, q.stg[`BSTP_CELL_STAGES-1:1]};
        end
        // only macrocell cells hold update stages
        if (IS_MACRO && i_update) begin
            d.upd_out = q.stg[`BSTP_STG_OUT];
            d.upd_oe  = q.stg[`BSTP_STG_OE];
        end
        if (i_rst) begin
            d = '0;
        end
    end

    always_ff @(posedge i_tck) begin
        q <= d;
    end

    assign o_scan_out = q.stg[0];
    assign o_upd_out  = q.upd_out;
    assign o_upd_oe   = q.upd_oe;

endmodule

`default_nettype wire

// ---- src/bstp_top.sv ----
// Purpose: boundary-scan test access port with its boundary cell chain
// Assumes: i_clk runs the pins and core side, i_tck runs the test port
// Notes:   chain order is input cells then I/O cells, data in to data out
`include "bstp_consts.svh"
`default_nettype none

module bstp_top
    import bstp_pkg::*;
#(
    parameter int          N_IN      = 4,
    parameter int          N_IO      = 64,
    // identification value is arbitrary, bit 0 set as boundary scan needs
    parameter logic [31:0] ID_VALUE  = 32'h1000_0001
) (
    input  wire logic                       i_clk,
    input  wire logic                       i_srst,
    input  wire logic                       i_tck,
    input  wire logic                       i_jtag_enable,
    input  wire logic [`BSTP_TAP_PINS-1:0]  i_tap_pin_in,
    input  wire logic [`BSTP_TAP_PINS-1:0]  i_tap_core_out,
    input  wire logic [`BSTP_TAP_PINS-1:0]  i_tap_core_oe,
    output logic      [`BSTP_TAP_PINS-1:0]  o_tap_core_in,
    output logic      [`BSTP_TAP_PINS-1:0]  o_tap_pin_out,
    output logic      [`BSTP_TAP_PINS-1:0]  o_tap_pin_oe,
    input  wire logic [N_IN-1:0]            i_in_pin,
    output logic      [N_IN-1:0]            o_in_core,
    input  wire logic [N_IO-1:0]            i_io_pin_in,
    input  wire logic [N_IO-1:0]            i_mc_out,
    input  wire logic [N_IO-1:0]            i_mc_oe,
    output logic      [N_IO-1:0]            o_io_core_in,
    output logic      [N_IO-1:0]            o_io_pin_out,
    output logic      [N_IO-1:0]            o_io_pin_oe,
    output logic                            o_test_mode
);

    // the four test port pins stay outside the chain; they serve
    // the port itself or, with the option off, plain user I/O
    localparam int NCELL = N_IN + N_IO;
    localparam int NPIN  = `BSTP_TAP_PINS + NCELL;
    localparam int IO0   = `BSTP_TAP_PINS + N_IN;

    // state of the pin side, on i_clk
    // s1..s3 form the pin filter; the _s fields bring test port
    // results over, two flops per bit, so bits may skew a cycle
    typedef struct packed {
        logic [NPIN-1:0]            s1;
        logic [NPIN-1:0]            s2;
        logic [NPIN-1:0]            s3;
        logic [NPIN-1:0]            pin;
        logic                       strap_done;
        logic                       jtag_en;
        logic                       tap_rst_req;
        logic [1:0]                 extest_s;
        logic [1:0]                 highz_s;
        logic [N_IO-1:0]            uo_s1;
        logic [N_IO-1:0]            uo_s2;
        logic [N_IO-1:0]            ue_s1;
        logic [N_IO-1:0]            ue_s2;
        logic [`BSTP_TAP_PINS-1:0]  tap_out;
        logic [`BSTP_TAP_PINS-1:0]  tap_oe;
        logic [`BSTP_TAP_PINS-1:0]  tap_core;
        logic [N_IN-1:0]            in_core;
        logic [N_IO-1:0]            io_core;
        logic [N_IO-1:0]            io_out;
        logic [N_IO-1:0]            io_oe;
    } bstp_clk_st_type;

    // state of the test port, on i_tck
    // ps, mo and me carry pin levels and macrocell drive for capture;
    // they lag the pins by a few cycles, which capture tolerates
    typedef struct packed {
        logic [1:0]                 rsync;
        bstp_tap_state_type         state;
        logic [`BSTP_IR_W-1:0]      ir_sh;
        logic [`BSTP_IR_W-1:0]      ir;
        logic                       byp;
        logic [`BSTP_ID_W-1:0]      id_sh;
        logic                       extest;
        logic                       highz;
        logic [NCELL-1:0]           ps1;
        logic [NCELL-1:0]           ps2;
        logic [N_IO-1:0]            mo1;
        logic [N_IO-1:0]            mo2;
        logic [N_IO-1:0]            me1;
        logic [N_IO-1:0]            me2;
    } bstp_tck_st_type;

    bstp_clk_st_type c_q, c_d;
    bstp_tck_st_type t_q, t_d;
    logic            tdo_q;
    logic            tdo_oe_q;

    logic [NCELL:0]  scan;
    logic [N_IO-1:0] upd_out;
    logic [N_IO-1:0] upd_oe;
    logic            t_rst;
    logic            bsr_sel;
    logic            is_idcode;
    logic            cell_cap;
    logic            cell_shift;
    logic            cell_upd;
    logic            tdo_next;

    // ---------------- pin side ----------------

    // pins pass three flops; a change counts once stages two and three agree
    always_comb begin
        c_d = c_q;
        c_d.s1 = {i_io_pin_in, i_in_pin, i_tap_pin_in};
        c_d.s2 = c_q.s1;
        c_d.s3 = c_q.s2;
        for (int k = 0; k < NPIN; k++) begin
            if (c_q.s2[k] == c_q.s3[k]) begin
                c_d.pin[k] = c_q.s3[k];
            end
        end
        // test mode flags and update values come over from the test clock
        c_d.extest_s = {c_q.extest_s[0], t_q.extest};
        c_d.highz_s  = {c_q.highz_s[0], t_q.highz};
        c_d.uo_s1    = upd_out;
        c_d.uo_s2    = c_q.uo_s1;
        c_d.ue_s1    = upd_oe;
        c_d.ue_s2    = c_q.ue_s1;
        // the port option is caught once, on the first edge after reset
        if (!c_q.strap_done) begin
            c_d.strap_done = 1'b1;
            c_d.jtag_en    = i_jtag_enable;
        end
        c_d.tap_rst_req = !c_q.jtag_en;
        // option off: the four test pins serve the core as plain I/O
        if (c_q.jtag_en) begin
            c_d.tap_out  = '0;
            c_d.tap_oe   = '0;
            c_d.tap_core = '0;
        end else begin
            c_d.tap_out  = i_tap_core_out;
            c_d.tap_oe   = i_tap_core_oe;
            c_d.tap_core = c_q.pin[`BSTP_TAP_PINS-1:0];
        end
        // core sees the filtered levels one register after the filter
        c_d.in_core = c_q.pin[`BSTP_TAP_PINS +: N_IN];
        c_d.io_core = c_q.pin[IO0 +: N_IO];
        // pin drivers: high-z wins over external test, then normal logic
        if (c_q.highz_s[1]) begin
            c_d.io_out = i_mc_out;
            c_d.io_oe  = '0;
        end else if (c_q.extest_s[1]) begin
            c_d.io_out = c_q.uo_s2;
            c_d.io_oe  = c_q.ue_s2;
        end else begin
            c_d.io_out = i_mc_out;
            c_d.io_oe  = i_mc_oe;
        end
        if (i_srst) begin
            c_d             = '0;
            c_d.tap_rst_req = 1'b1;
        end
    end

    // one register stage for the whole pin side
    always_ff @(posedge i_clk) begin
        c_q <= c_d;
    end

    // ---------------- test port side ----------------

    // the port sits in reset during i_srst and while the option is off,
    // so no power-up sequence on the pins is needed to reach a known state
    assign t_rst = t_q.rsync[1];

    // decode; codes outside the five fall back to the bypass bit
    // highz also shifts through the bypass bit while the pins float
    always_comb begin
        bsr_sel   = (t_q.ir == `BSTP_OP_SAMPLE) || (t_q.ir == `BSTP_OP_EXTEST);
        is_idcode = (t_q.ir == `BSTP_OP_IDCODE);
    end

    // cell strobes come from the controller state, gated by the chain select
    // bypass, identification and highz leave the chain untouched
    always_comb begin
        cell_cap   = bsr_sel && (t_q.state == TAP_CAP_DR);
        cell_shift = bsr_sel && (t_q.state == TAP_SHIFT_DR);
        cell_upd   = bsr_sel && (t_q.state == TAP_UPD_DR);
    end

    // controller, instruction, bypass and identification registers
    always_comb begin
        t_d = t_q;
        // reset request crosses as a level; first flop feeds only the second
        t_d.rsync = {t_q.rsync[0], c_q.tap_rst_req};
        t_d.ps1   = c_q.pin[`BSTP_TAP_PINS +: NCELL];
        t_d.ps2   = t_q.ps1;
        t_d.mo1   = i_mc_out;
        t_d.mo2   = t_q.mo1;
        t_d.me1   = i_mc_oe;
        t_d.me2   = t_q.me1;
        // standard walk steered by the mode pin on each rising edge;
        // five clocks with the mode pin high reach reset from anywhere
        case (t_q.state)
            TAP_RESET:    t_d.state = i_tap_pin_in[`BSTP_PIN_TMS] ? TAP_RESET : TAP_IDLE;
            TAP_IDLE:     t_d.state = i_tap_pin_in[`BSTP_PIN_TMS] ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR:   t_d.state = i_tap_pin_in[`BSTP_PIN_TMS] ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR:   t_d.state = i_tap_pin_in[`BSTP_PIN_TMS] ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: t_d.state = i_tap_pin_in[`BSTP_PIN_TMS] ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: t_d.state = i_tap_pin_in[`BSTP_PIN_TMS] ? TAP_UPD_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: t_d.state = i_tap_pin_in[`BSTP_PIN_TMS] ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: t_d.state = i_tap_pin_in[`BSTP_PIN_TMS] ? TAP_UPD_DR : TAP_SHIFT_DR;
            TAP_UPD_DR:   t_d.state = i_tap_pin_in[`BSTP_PIN_TMS] ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR:   t_d.state = i_tap_pin_in[`BSTP_PIN_TMS] ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR:   t_d.state = i_tap_pin_in[`BSTP_PIN_TMS] ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: t_d.state = i_tap_pin_in[`BSTP_PIN_TMS] ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: t_d.state = i_tap_pin_in[`BSTP_PIN_TMS] ? TAP_UPD_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: t_d.state = i_tap_pin_in[`BSTP_PIN_TMS] ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: t_d.state = i_tap_pin_in[`BSTP_PIN_TMS] ? TAP_UPD_IR : TAP_SHIFT_IR;
            TAP_UPD_IR:   t_d.state = i_tap_pin_in[`BSTP_PIN_TMS] ? TAP_SEL_DR : TAP_IDLE;
            default:      t_d.state = TAP_RESET;
        endcase
        // instruction shifter and its update
        case (t_q.state)
            TAP_CAP_IR:   t_d.ir_sh = `BSTP_IR_CAPTURE;
            TAP_SHIFT_IR: t_d.ir_sh = {i_tap_pin_in[`BSTP_PIN_TDI],
                                       t_q.ir_sh[`BSTP_IR_W-1:1]};
            TAP_UPD_IR:   t_d.ir    = t_q.ir_sh;
            TAP_RESET:    t_d.ir    = `BSTP_IR_RESET;
            default:      t_d.ir    = t_q.ir;
        endcase
        // one-bit bypass and 32-bit identification paths
        if (t_q.state == TAP_CAP_DR) begin
            t_d.byp   = 1'b0;
            t_d.id_sh = ID_VALUE;
        end else if (t_q.state == TAP_SHIFT_DR) begin
            t_d.byp = i_tap_pin_in[`BSTP_PIN_TDI];
            if (is_idcode) begin
                t_d.id_sh = {i_tap_pin_in[`BSTP_PIN_TDI], t_q.id_sh[`BSTP_ID_W-1:1]};
            end
        end
        // pin modes follow the active instruction
        t_d.extest = (t_q.ir == `BSTP_OP_EXTEST);
        t_d.highz  = (t_q.ir == `BSTP_OP_HIGHZ);
        // reset leaves identification active, so a bare data scan
        // straight after power-up reads the identification value
        if (t_rst) begin
            t_d.state  = TAP_RESET;
            t_d.ir     = `BSTP_IR_RESET;
            t_d.ir_sh  = '0;
            t_d.byp    = 1'b0;
            t_d.id_sh  = '0;
            t_d.extest = 1'b0;
            t_d.highz  = 1'b0;
        end
    end

    // the test port state moves on the rising test clock, all but the data out flops
    always_ff @(posedge i_tck) begin
        t_q <= t_d;
    end

    // data out picks the register that sits between data in and data out
    always_comb begin
        if (t_q.state == TAP_SHIFT_IR) begin
            tdo_next = t_q.ir_sh[0];
        end else if (bsr_sel) begin
            tdo_next = scan[NCELL];
        end else if (is_idcode) begin
            tdo_next = t_q.id_sh[0];
        end else begin
            tdo_next = t_q.byp;
        end
    end

    // data out moves on the falling edge so the tester samples it settled
    // the enable drops outside the shift states, so the pin floats then
    always_ff @(negedge i_tck) begin
        if (t_rst) begin
            tdo_q    <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else begin
            tdo_q    <= tdo_next;
            tdo_oe_q <= (t_q.state == TAP_SHIFT_IR) || (t_q.state == TAP_SHIFT_DR);
        end
    end

    // ---------------- boundary cell chain ----------------

    // test port pins are left out of the chain; only inputs and I/O cells
    // cell 0 sits next to data in, so the last I/O cell leaves first
    assign scan[0] = i_tap_pin_in[`BSTP_PIN_TDI];
    generate
        for (genvar k = 0; k < NCELL; k++) begin : g_cell
            logic [`BSTP_CELL_STAGES-1:0] cap;
            logic                         u_out;
            logic                         u_oe;
            if (k < N_IN) begin : g_in
                // input cells see their pin only
                assign cap = {2'h0, t_q.ps2[k]};
            end else begin : g_mc
                // macrocell cells see pin, macrocell output and its enable
                assign cap = {t_q.me2[k-N_IN], t_q.mo2[k-N_IN], t_q.ps2[k]};
                assign upd_out[k-N_IN] = u_out;
                assign upd_oe[k-N_IN]  = u_oe;
            end
            // only macrocell cells keep update stages
            bstp_cell #(
                .IS_MACRO (k >= N_IN)
            ) u_cell (
                .i_tck      (i_tck),
                .i_rst      (t_rst),
                .i_capture  (cell_cap),
                .i_shift    (cell_shift),
                .i_update   (cell_upd),
                .i_scan_in  (scan[k]),
                .i_cap      (cap),
                .o_scan_out (scan[k+1]),
                .o_upd_out  (u_out),
                .o_upd_oe   (u_oe)
            );
        end
    endgenerate

    // ---------------- outputs ----------------

    // test data out shares its pin with the user function when the port is off
    // the option is fixed after reset, so this select never moves in use
    always_comb begin
        o_tap_pin_out = c_q.tap_out;
        o_tap_pin_oe  = c_q.tap_oe;
        if (c_q.jtag_en) begin
            o_tap_pin_out[`BSTP_PIN_TDO] = tdo_q;
            o_tap_pin_oe[`BSTP_PIN_TDO]  = tdo_oe_q;
        end
    end

    // the remaining outputs are plain registers of the pin side
    assign o_tap_core_in = c_q.tap_core;
    assign o_in_core     = c_q.in_core;
    assign o_io_core_in  = c_q.io_core;
    assign o_io_pin_out  = c_q.io_out;
    assign o_io_pin_oe   = c_q.io_oe;
    assign o_test_mode   = c_q.jtag_en;

endmodule

`default_nettype wire

// ---- testbench/bstp_sva.sv ----
// Purpose: port-level checks of the boundary-scan test port
// Assumes: the port option only changes while reset is high
// Notes:   all checks live in the 100 MHz pin domain
`include "bstp_consts.svh"
`default_nettype none

module bstp_sva #(
    parameter int N_IN = 4,
    parameter int N_IO = 64
) (
    input wire logic                      i_clk,
    input wire logic                      i_srst,
    input wire logic                      i_jtag_enable,
    input wire logic [`BSTP_TAP_PINS-1:0] i_tap_pin_in,
    input wire logic [`BSTP_TAP_PINS-1:0] o_tap_core_in,
    input wire logic [`BSTP_TAP_PINS-1:0] o_tap_pin_oe,
    input wire logic [N_IN-1:0]           i_in_pin,
    input wire logic [N_IN-1:0]           o_in_core,
    input wire logic [N_IO-1:0]           i_io_pin_in,
    input wire logic [N_IO-1:0]           o_io_core_in,
    input wire logic [N_IO-1:0]           i_mc_out,
    input wire logic [N_IO-1:0]           i_mc_oe,
    input wire logic [N_IO-1:0]           o_io_pin_out,
    input wire logic [N_IO-1:0]           o_io_pin_oe,
    input wire logic                      o_test_mode
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    // reset must quiet the pins even though it is the disable condition elsewhere
    rst_quiet_a: assert property (disable iff (1'b0)
        i_srst |=> o_io_pin_oe == '0 && !o_test_mode)
        else $error("pins driven during reset");
    mode_latch_a: assert property (!i_srst [*4] |-> o_test_mode == $past(i_jtag_enable, 3))
        else $error("port option not latched");
    mode_hold_a: assert property (!i_srst [*4] |-> $stable(o_test_mode))
        else $error("port option moved without reset");
    core_mask_a: assert property (o_test_mode [*4] |-> o_tap_core_in == '0)
        else $error("test pins leak to core in port mode");
    tap_input_a: assert property (o_test_mode [*4] |-> o_tap_pin_oe[2:0] == '0)
        else $error("test input pin driven in port mode");
    in_follow_a: assert property ($stable(i_in_pin) [*8] |-> o_in_core == i_in_pin)
        else $error("input pin not seen by core");
    io_core_a: assert property ($stable(i_io_pin_in) [*8] |-> o_io_core_in == i_io_pin_in)
        else $error("io pin not seen by core");
    io_drive_a: assert property ((!o_test_mode && $stable({i_mc_out, i_mc_oe})) [*6]
        |-> o_io_pin_out == i_mc_out && o_io_pin_oe == i_mc_oe)
        else $error("io pin not driven by macrocell");
    tap_user_a: assert property ((!o_test_mode && $stable(i_tap_pin_in)) [*8]
        |-> o_tap_core_in == i_tap_pin_in)
        else $error("test pin not a user pin with port off");

    // main scenarios: port on, high impedance, data output enabled
    cover property (o_test_mode [*8]);
    cover property (o_test_mode && o_io_pin_oe == '0 && i_mc_oe != '0);
    cover property ($rose(o_tap_pin_oe[3]));
endmodule

bind bstp_top bstp_sva #(.N_IN(N_IN), .N_IO(N_IO)) u_sva (.*);

`default_nettype wire

// ---- testbench/bstp_tester.sv ----
// Purpose: model of the external scan controller on the four test pins
// Assumes: the device changes its data output on the falling test clock
// Notes:   the test clock runs only inside tasks, so it stands still between frames
`default_nettype none

module bstp_tester (
    output logic      o_tck,
    output logic      o_tms,
    output logic      o_tdi,
    input  wire logic i_tdo,
    input  wire logic i_tdo_oe,
    output logic      o_tdo_seen
);
    timeunit 1ns;
    timeprecision 100ps;

    // a released data output shows the inverse of its last level, not a lucky guess
    assign o_tdo_seen = i_tdo_oe ? i_tdo : ~i_tdo;

    initial begin
        o_tck = 1'b0;
        o_tms = 1'b1;
        o_tdi = 1'b1;
    end

    // one test clock: steer after the falling edge, sample just before rising
    task automatic tick(input logic m, input logic d, output logic o);
        o_tms = m;
        o_tdi = d;
        #62.5;
        o = o_tdo_seen;
        o_tck = 1'b1;
        #62.5;
        o_tck = 1'b0;
    endtask

    // n clocks at a fixed mode level
    task automatic run(input int n, input logic m);
        logic o;
        repeat (n) tick(m, 1'b1, o);
    endtask

    // instruction or data scan from idle back to idle, lsb first
    task automatic scan(input bit ir, input int len, input logic [255:0] din,
                        output logic [255:0] dout);
        logic o;
        dout = '0;
        tick(1'b1, 1'b1, o);
        if (ir) tick(1'b1, 1'b1, o);
        tick(1'b0, 1'b1, o);
        tick(1'b0, 1'b1, o);
        for (int i = 0; i < len; i++) begin
            tick(i == len - 1, din[i], o);
            dout[i] = o;
        end
        tick(1'b1, 1'b1, o);
        tick(1'b0, 1'b1, o);
    endtask
endmodule

`default_nettype wire

// ---- testbench/boundary_scan_test_port_test.sv ----
// Purpose: self-checking bench of the boundary-scan test port
// Assumes: the scan controller model owns the test pins while the port is on
// Notes:   expected scan data is built from pin levels, never from outputs
`default_nettype none

module boundary_scan_test_port_test;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int NC = 3 * (4 + 64);
    localparam logic [255:0] MASK = (256'h1 << NC) - 1;
    localparam logic [31:0] ID = 32'h5a3c_0f01; // arbitrary value, bit 0 set
    localparam logic [3:0] OPS [6] = '{4'hf, 4'h7, 4'h2, 4'h1, 4'h0, 4'h3};

    logic         clk = 1'b0;
    logic         srst = 1'b1;
    logic         en = 1'b0;
    logic [3:0]   tap_rnd = '0, core_out = '0, core_oe = '0, in_pin = '0;
    logic [63:0]  io_in = '0, mc_out = '0, mc_oe = '0;
    logic [3:0]   tap_core_in, tap_out, tap_oe, in_core;
    logic [63:0]  io_core, io_out, io_oe;
    logic         test_mode, tck, tms, tdi, tdo_seen;
    logic [31:0]  seed = 32'h64f6049a;
    logic [255:0] got;
    int           err_count = 0, checks_done = 0, cycles = 0;
    wire logic [3:0] tap_in = en ? {tdo_seen, tck, tms, tdi} : tap_rnd;

    bstp_top #(.ID_VALUE(ID)) u_bstp_top (
        .i_clk(clk), .i_srst(srst), .i_tck(tck), .i_jtag_enable(en),
        .i_tap_pin_in(tap_in), .i_tap_core_out(core_out), .i_tap_core_oe(core_oe),
        .o_tap_core_in(tap_core_in), .o_tap_pin_out(tap_out), .o_tap_pin_oe(tap_oe),
        .i_in_pin(in_pin), .o_in_core(in_core), .i_io_pin_in(io_in), .i_mc_out(mc_out),
        .i_mc_oe(mc_oe), .o_io_core_in(io_core), .o_io_pin_out(io_out),
        .o_io_pin_oe(io_oe), .o_test_mode(test_mode));

    bstp_tester u_bstp_tester (.o_tck(tck), .o_tms(tms), .o_tdi(tdi),
        .i_tdo(tap_out[3]), .i_tdo_oe(tap_oe[3]), .o_tdo_seen(tdo_seen));

    // 100 MHz pin clock
    always #5 clk = ~clk;

    // hang guard, well above the longest scan sequence
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            err_count++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [255:0] g, input logic [255:0] e);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        repeat (32) s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
        return s;
    endfunction

    // new random levels on every pin and macrocell input
    task automatic stir();
        logic [31:0] r [7];
        foreach (r[i]) begin
            seed = lfsr(seed);
            r[i] = seed;
        end
        @(posedge clk);
        in_pin   <= r[0][3:0];
        tap_rnd  <= r[0][7:4];
        core_out <= r[0][11:8];
        core_oe  <= r[0][15:12];
        io_in    <= {r[1], r[2]};
        mc_out   <= {r[3], r[4]};
        mc_oe    <= {r[5], r[6]};
    endtask

    // test clock keeps running in reset so the port domain leaves its unknown state
    task automatic do_reset(input logic on);
        @(posedge clk);
        srst <= 1'b1;
        en   <= on;
        fork
            repeat (20) @(posedge clk);
            u_bstp_tester.run(3, 1'b1);
        join
        @(posedge clk);
        srst <= 1'b0;
        repeat (4) @(posedge clk);
        u_bstp_tester.run(3, 1'b1);
        u_bstp_tester.run(1, 1'b0);
    endtask

    // expected capture: first bit out is the last cell's pin stage
    function automatic logic [255:0] chain_exp();
        logic [255:0] v;
        int c;
        v = '0;
        for (int k = 0; k < 68; k++) begin
            c = 67 - k;
            if (c < 4) v[3*k] = in_pin[c];
            else v[3*k +: 3] = {mc_oe[c-4], mc_out[c-4], io_in[c-4]};
        end
        return v;
    endfunction

    // pin drive from the update stages: out is stage 1, enable stage 2
    function automatic logic [127:0] ext_exp(input logic [255:0] p);
        logic [127:0] v;
        for (int io = 0; io < 64; io++) begin
            v[64 + io] = p[3*(63-io) + 1];
            v[io]      = p[3*(63-io) + 2];
        end
        return v;
    endfunction

    // port off first, then every opcode with the port on
    initial begin
        logic [255:0] p, e;
        do_reset(1'b0);
        repeat (4) begin
            stir();
            repeat (10) @(posedge clk);
            chk(in_core, in_pin);
            chk(io_core, io_in);
            chk({io_out, io_oe}, {mc_out, mc_oe});
            chk({tap_core_in, tap_out, tap_oe}, {tap_rnd, core_out, core_oe});
            chk(test_mode, 1'b0);
        end
        $display("test user pins done");
        do_reset(1'b1);
        u_bstp_tester.scan(1'b0, 32, '0, got);
        chk(got[31:0], ID);
        chk(test_mode, 1'b1);
        $display("test reset instruction done");
        foreach (OPS[i]) begin
            stir();
            for (int j = 0; j < 8; j++) begin
                seed = lfsr(seed);
                p[32*j +: 32] = seed;
            end
            p = p & MASK;
            u_bstp_tester.scan(1'b1, 4, 256'(OPS[i]), got);
            chk(got[3:0], 4'h1);
            repeat (8) @(posedge clk);
            u_bstp_tester.scan(1'b0, NC, p, got);
            case (OPS[i])
                4'h1, 4'h0: e = chain_exp();
                4'h2: e = (p << 32) | 256'(ID);
                default: e = p << 1;
            endcase
            chk(got, e & MASK);
            repeat (10) @(posedge clk);
            if (OPS[i] == 4'h0) chk({io_out, io_oe}, ext_exp(p));
            if (OPS[i] == 4'h3) chk(io_oe, '0);
            $display("test opcode %h done", OPS[i]);
        end
        wrap_up();
    end
endmodule

`default_nettype wire
